// [bench/timer8_ctrl_irq_regs_bench.sv]
// self-checking bench for the 8-bit timer register block
`timescale 1ns/1ps
`define CHK(got, exp) begin samples_checked++; if ((got) !== (exp)) begin \
	n_mismatch++; $display("Error %0t: got %h exp %h", $time, got, exp); end end
module timer8_ctrl_irq_regs_bench;
	// ==========================================================
	// signals
	logic        pclk;
	logic        presetn;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [7:0]  paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        ext_count_pin;
	logic        global_irq_en;
	logic        vec_ack_cmp_a;
	logic        vec_ack_ovf;
	logic        vec_ack_cmp_b;
	logic        irq_cmp_a;
	logic        irq_ovf;
	logic        irq_cmp_b;
	logic        wave_out_a;
	logic        wave_out_a_conn;
	logic        wave_out_b;
	logic        wave_out_b_conn;
	int          n_mismatch;
	int          samples_checked;
	logic [31:0] rd_word;
	logic        rd_err;
	logic [7:0]  v;
	int          divs [5] = '{1, 8, 64, 256, 1024};

	timer8_ctrl_irq_regs u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.ext_count_pin(ext_count_pin), .global_irq_en(global_irq_en),
		.vec_ack_cmp_a(vec_ack_cmp_a), .vec_ack_ovf(vec_ack_ovf),
		.vec_ack_cmp_b(vec_ack_cmp_b), .irq_cmp_a(irq_cmp_a),
		.irq_ovf(irq_ovf), .irq_cmp_b(irq_cmp_b), .wave_out_a(wave_out_a),
		.wave_out_a_conn(wave_out_a_conn), .wave_out_b(wave_out_b),
		.wave_out_b_conn(wave_out_b_conn));

	// ==========================================================
	// apb master
	task automatic apb(input logic wr, input logic [7:0] idx,
		input logic [7:0] wd);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= {idx[5:0], 2'b00};
		pwdata <= {24'h000000, wd};
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		// only the watchdog ends a wait that never sees ready
		while (pready !== 1'b1) begin
			@(posedge pclk);
		end
		rd_word = prdata;
		rd_err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] idx, input logic [7:0] d);
		apb(1'b1, idx, d);
	endtask
	task automatic rd(input logic [7:0] idx);
		apb(1'b0, idx, 8'h00);
		v = rd_word[7:0];
	endtask
	task automatic pulse(input logic [2:0] acks);
		@(posedge pclk);
		{vec_ack_cmp_b, vec_ack_ovf, vec_ack_cmp_a} <= acks;
		@(posedge pclk);
		{vec_ack_cmp_b, vec_ack_ovf, vec_ack_cmp_a} <= 3'b000;
		@(posedge pclk);
	endtask

	// ==========================================================
	// scenarios
	task automatic t_regs;
		rd(timer8_pkg::IDX_CNT);
		`CHK(v, timer8_pkg::RST_CNT)
		rd(timer8_pkg::IDX_CMP_B);
		`CHK(v, timer8_pkg::RST_CMP)
		wr(timer8_pkg::IDX_CTRL_B, 8'hf8);
		rd(timer8_pkg::IDX_CTRL_B);
		`CHK(v, 8'h08)
		wr(timer8_pkg::IDX_CTRL_B, 8'h00);
		wr(timer8_pkg::IDX_CNT, 8'h5a);
		rd(timer8_pkg::IDX_CNT);
		`CHK(v, 8'h5a)
		rd(8'h20);
		`CHK({rd_err, rd_word}, {1'b1, 32'h00000000})
		$display("test regs done");
	endtask

	task automatic t_force;
		wr(timer8_pkg::IDX_MASK, 8'h07);
		global_irq_en <= 1'b1;
		for (int i = 1; i < 4; i++) begin
			wr(timer8_pkg::IDX_CTRL_A, {2'(i), 6'h00});
			wr(timer8_pkg::IDX_CTRL_B, 8'h80);
			repeat (2) @(posedge pclk);
			`CHK(wave_out_a, (i == 2) ? 1'b0 : 1'b1)
		end
		`CHK(wave_out_a_conn, 1'b1)
		wr(timer8_pkg::IDX_CTRL_A, 8'h30);
		wr(timer8_pkg::IDX_CTRL_B, 8'h40);
		repeat (2) @(posedge pclk);
		`CHK(wave_out_b, 1'b1)
		`CHK(wave_out_b_conn, 1'b1)
		`CHK({irq_cmp_a, irq_cmp_b}, 2'b00)
		rd(timer8_pkg::IDX_FLAGS);
		`CHK(v, 8'h00)
		wr(timer8_pkg::IDX_CTRL_A, 8'h81);
		wr(timer8_pkg::IDX_CTRL_B, 8'h80);
		repeat (2) @(posedge pclk);
		`CHK(wave_out_a, 1'b1)
		wr(timer8_pkg::IDX_CTRL_B, 8'h00);
		wr(timer8_pkg::IDX_CTRL_A, 8'h00);
		wr(timer8_pkg::IDX_MASK, 8'h00);
		global_irq_en <= 1'b0;
		`CHK({wave_out_a_conn, wave_out_b_conn}, 2'b00)
		$display("test force done");
	endtask

	task automatic t_prescale;
		logic [7:0] held;
		for (int c = 0; c < 5; c++) begin
			wr(timer8_pkg::IDX_CNT, 8'h00);
			wr(timer8_pkg::IDX_CTRL_B, 8'(c + 1));
			repeat (4 * divs[c]) @(posedge pclk);
			wr(timer8_pkg::IDX_CTRL_B, 8'h00);
			rd(timer8_pkg::IDX_CNT);
			`CHK(v >= 3 && v <= (4 * divs[c] + 3) / divs[c] + 1, 1'b1)
		end
		// a stopped counter must hold its value exactly
		held = v;
		repeat (20) @(posedge pclk);
		rd(timer8_pkg::IDX_CNT);
		`CHK(v, held)
		$display("test prescale done");
	endtask

	task automatic t_ext;
		for (int m = 0; m < 2; m++) begin
			wr(timer8_pkg::IDX_CNT, 8'h00);
			wr(timer8_pkg::IDX_CTRL_B, 8'(6 + m));
			repeat (4) begin
				@(posedge pclk);
				ext_count_pin <= 1'b1;
				repeat (2) @(posedge pclk);
				ext_count_pin <= 1'b0;
				repeat (2) @(posedge pclk);
			end
			wr(timer8_pkg::IDX_CTRL_B, 8'h00);
			rd(timer8_pkg::IDX_CNT);
			`CHK(v, 8'h04)
		end
		$display("test ext done");
	endtask

	task automatic t_match;
		wr(timer8_pkg::IDX_FLAGS, 8'h07);
		wr(timer8_pkg::IDX_CMP_A, 8'h40);
		wr(timer8_pkg::IDX_CMP_B, 8'h44);
		wr(timer8_pkg::IDX_CTRL_B, 8'h01);
		wr(timer8_pkg::IDX_CNT, 8'h40);
		wr(timer8_pkg::IDX_CTRL_B, 8'h00);
		rd(timer8_pkg::IDX_FLAGS);
		`CHK(v, 8'h00)
		wr(timer8_pkg::IDX_CNT, 8'h3c);
		wr(timer8_pkg::IDX_CTRL_B, 8'h01);
		repeat (2) @(posedge pclk);
		// this clear lands on the tick that matches channel a
		wr(timer8_pkg::IDX_FLAGS, 8'h01);
		repeat (2) @(posedge pclk);
		wr(timer8_pkg::IDX_CTRL_B, 8'h00);
		rd(timer8_pkg::IDX_FLAGS);
		`CHK(v, 8'h05)
		wr(timer8_pkg::IDX_MASK, 8'h05);
		global_irq_en <= 1'b1;
		@(negedge pclk);
		`CHK({irq_cmp_b, irq_ovf, irq_cmp_a}, 3'b101)
		@(posedge pclk);
		global_irq_en <= 1'b0;
		@(negedge pclk);
		`CHK({irq_cmp_b, irq_cmp_a}, 2'b00)
		wr(timer8_pkg::IDX_FLAGS, 8'h04);
		rd(timer8_pkg::IDX_FLAGS);
		`CHK(v, 8'h01)
		pulse(3'b001);
		rd(timer8_pkg::IDX_FLAGS);
		`CHK(v, 8'h00)
		$display("test match done");
	endtask

	task automatic t_ovf;
		wr(timer8_pkg::IDX_CMP_B, 8'hfc);
		wr(timer8_pkg::IDX_CNT, 8'hf8);
		wr(timer8_pkg::IDX_MASK, 8'h02);
		wr(timer8_pkg::IDX_CTRL_B, 8'h01);
		repeat (12) @(posedge pclk);
		wr(timer8_pkg::IDX_CTRL_B, 8'h00);
		rd(timer8_pkg::IDX_CNT);
		`CHK(v, 8'h07)
		rd(timer8_pkg::IDX_FLAGS);
		`CHK(v, 8'h06)
		global_irq_en <= 1'b1;
		@(negedge pclk);
		`CHK({irq_cmp_b, irq_ovf}, 2'b01)
		wr(timer8_pkg::IDX_FLAGS, 8'h01);
		rd(timer8_pkg::IDX_FLAGS);
		`CHK(v, 8'h06)
		pulse(3'b100);
		rd(timer8_pkg::IDX_FLAGS);
		`CHK(v, 8'h02)
		pulse(3'b010);
		`CHK(irq_ovf, 1'b0)
		global_irq_en <= 1'b0;
		$display("test ovf done");
	endtask

	// ==========================================================
	// run control
	task automatic report_and_stop;
		$display("checked %0d mismatches %0d", samples_checked, n_mismatch);
		if (n_mismatch == 0 && samples_checked > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	initial begin
		pclk = 1'b0;
		forever #25 pclk = ~pclk;
	end

	// the longest test is the prescaler sweep up to divide-by-1024, about 5.5k cycles
	initial begin
		repeat (20000) @(posedge pclk);
		n_mismatch++;
		report_and_stop;
	end

	initial begin
		presetn = 1'b0;
		{psel, penable, pwrite, paddr, pwdata} = '0;
		{ext_count_pin, global_irq_en} = 2'b00;
		{vec_ack_cmp_a, vec_ack_ovf, vec_ack_cmp_b} = 3'b000;
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		t_regs;
		t_force;
		t_prescale;
		t_ext;
		t_match;
		t_ovf;
		report_and_stop;
	end
endmodule // timer8_ctrl_irq_regs_bench

// [verilog/timer8_ctrl_irq_regs.sv]
// 8-bit timer with compare channels, flags and apb registers
// How it works
// [R1] counter max is 0xff and bottom is 0x00
// [R2] force bits act only in non-pwm waveform modes
// [R3] force strobe applies a compare match to the waveform at once
// [R4] force sets no flag, raises no interrupt, never clears counter
// [R5] force bits are write-only strobes that read as zero
// [R6] software writes force bits as zero while in a pwm mode
// [R7] clock select: stop, undivided, divide by 8, 64, 256, 1024
// [R8] codes 110 and 111 count falling or rising pin edges
// [R9] pin edges count even when the pin is an output
// [R10] reserved bits 5:4 of control b read as zero
// [R11] counter register is directly readable and writable
// [R12] a counter write blocks the match on the next tick
// [R13] both compare registers are always compared with the counter
// [R14] a match sets the channel compare flag
// [R15] overflow flag set at max, top or bottom by mode
// [R16] interrupt when flag, its enable and global enable are set
// [R17] taking the interrupt vector clears its flag
// [R18] writing one clears a flag, zero leaves it
// [R19] waveform mode is high bit of b with low bits of a
// [R20] non-pwm output modes: port, toggle, clear, set on match
// [R21] hardware flag set wins over a same-cycle software clear
`timescale 1ns/1ps
module timer8_ctrl_irq_regs (
	// clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// apb slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// external count pin
	input  wire logic        ext_count_pin,
	// processor side
	input  wire logic        global_irq_en,
	input  wire logic        vec_ack_cmp_a,
	input  wire logic        vec_ack_ovf,
	input  wire logic        vec_ack_cmp_b,
	output logic             irq_cmp_a,
	output logic             irq_ovf,
	output logic             irq_cmp_b,
	// waveform outputs
	output logic             wave_out_a,
	output logic             wave_out_a_conn,
	output logic             wave_out_b,
	output logic             wave_out_b_conn
);
	// ==========================================================
	// decode helpers
	function automatic logic reg_hit(input logic [7:0] addr,
		input logic [7:0] idx);
		reg_hit = (addr == {idx[5:0], 2'b00});
	endfunction

	function automatic logic is_pwm(input logic [2:0] wm);
		is_pwm = (wm[0] == 1'b1);
	endfunction

	function automatic logic [9:0] pre_mask(input logic [10:0] div);
		pre_mask = 10'(div - 11'h001);
	endfunction

	// ==========================================================
	// state
	logic [7:0] cnt_ff;
	logic [7:0] cmp_ff [2];
	logic [7:0] ctrl_a_ff;
	logic       wm_hi_ff;
	logic [2:0] cs_ff;
	logic [2:0] flags_ff;
	logic [2:0] mask_ff;
	logic       dir_down_ff;
	logic       block_ff;
	logic [9:0] presc_ff;
	logic       ext_prev_ff;
	logic       wave_ff [2];
	logic [31:0] prdata_ff;

	logic [2:0] wmode;
	logic [1:0] omode [2];
	logic       wr_acc;
	logic       wr_cnt;
	logic       wr_ctrl_b;
	logic       wr_flags;
	logic       mapped;
	logic       tmr_tick;
	logic       pre_tick;
	logic       phase_mode;
	logic       top_is_cmp;
	logic [7:0] top_val;
	logic [1:0] hit;
	logic [1:0] force_cmp;
	logic       ovf_evt;
	logic       at_bottom_wrap;
	logic [2:0] set_evt;
	logic [2:0] clr_evt;
	logic [2:0] nxt_flags;
	logic [31:0] nxt_prdata;

	// ==========================================================
	// apb decode
	assign wmode   = {wm_hi_ff, ctrl_a_ff[timer8_pkg::WM_LO_LSB +: 2]}; // see [R19]
	assign omode[0] = ctrl_a_ff[timer8_pkg::OM_A_LSB +: 2];
	assign omode[1] = ctrl_a_ff[timer8_pkg::OM_B_LSB +: 2];

	assign mapped = reg_hit(paddr, timer8_pkg::IDX_CMP_B)
		| reg_hit(paddr, timer8_pkg::IDX_CMP_A)
		| reg_hit(paddr, timer8_pkg::IDX_CNT)
		| reg_hit(paddr, timer8_pkg::IDX_CTRL_B)
		| reg_hit(paddr, timer8_pkg::IDX_CTRL_A)
		| reg_hit(paddr, timer8_pkg::IDX_FLAGS)
		| reg_hit(paddr, timer8_pkg::IDX_MASK);
	// zero wait states keep the access phase to one cycle
	assign pready  = 1'b1;
	assign pslverr = psel & penable & ~mapped;
	assign wr_acc  = psel & penable & pwrite & mapped;
	assign wr_cnt    = wr_acc & reg_hit(paddr, timer8_pkg::IDX_CNT);
	assign wr_ctrl_b = wr_acc & reg_hit(paddr, timer8_pkg::IDX_CTRL_B);
	assign wr_flags  = wr_acc & reg_hit(paddr, timer8_pkg::IDX_FLAGS);

	// read data is caught in the setup cycle, held for access
	always_comb begin
		nxt_prdata = 32'h0000_0000;
		if (reg_hit(paddr, timer8_pkg::IDX_CMP_B)) begin
			nxt_prdata[7:0] = cmp_ff[1];
		end
		if (reg_hit(paddr, timer8_pkg::IDX_CMP_A)) begin
			nxt_prdata[7:0] = cmp_ff[0];
		end
		if (reg_hit(paddr, timer8_pkg::IDX_CNT)) begin
			nxt_prdata[7:0] = cnt_ff; // see [R11]
		end
		if (reg_hit(paddr, timer8_pkg::IDX_CTRL_B)) begin
			// force and reserved bits stay zero, see [R5] see [R10]
			nxt_prdata[timer8_pkg::WM_HI_BIT] = wm_hi_ff;
			nxt_prdata[timer8_pkg::CS_LSB +: 3] = cs_ff;
		end
		if (reg_hit(paddr, timer8_pkg::IDX_CTRL_A)) begin
			nxt_prdata[7:0] = ctrl_a_ff & 8'hf3;
		end
		if (reg_hit(paddr, timer8_pkg::IDX_FLAGS)) begin
			nxt_prdata[2:0] = flags_ff;
		end
		if (reg_hit(paddr, timer8_pkg::IDX_MASK)) begin
			nxt_prdata[2:0] = mask_ff;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_ff <= 32'h0000_0000;
		end else if (psel && !penable && !pwrite) begin
			prdata_ff <= nxt_prdata;
		end
	end
	assign prdata = prdata_ff;

	// ==========================================================
	// control registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cmp_ff[0] <= timer8_pkg::RST_CMP;
			cmp_ff[1] <= timer8_pkg::RST_CMP;
			ctrl_a_ff <= timer8_pkg::RST_CTRL;
			wm_hi_ff  <= 1'b0;
			cs_ff     <= timer8_pkg::CS_STOP;
			mask_ff   <= timer8_pkg::RST_MASK;
		end else if (wr_acc) begin
			if (reg_hit(paddr, timer8_pkg::IDX_CMP_A)) begin
				cmp_ff[0] <= pwdata[7:0];
			end
			if (reg_hit(paddr, timer8_pkg::IDX_CMP_B)) begin
				cmp_ff[1] <= pwdata[7:0];
			end
			if (reg_hit(paddr, timer8_pkg::IDX_CTRL_A)) begin
				ctrl_a_ff <= pwdata[7:0] & 8'hf3;
			end
			if (wr_ctrl_b) begin
				wm_hi_ff <= pwdata[timer8_pkg::WM_HI_BIT];
				cs_ff    <= pwdata[timer8_pkg::CS_LSB +: 3];
			end
			if (reg_hit(paddr, timer8_pkg::IDX_MASK)) begin
				mask_ff <= pwdata[2:0];
			end
		end
	end

	// ==========================================================
	// clock select and prescaler
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			presc_ff    <= 10'h000;
			ext_prev_ff <= 1'b0;
		end else begin
			presc_ff    <= presc_ff + 10'h001;
			// pin is sampled regardless of its direction, see [R9]
			ext_prev_ff <= ext_count_pin;
		end
	end

	always_comb begin
		case (cs_ff) // see [R7] see [R8]
		timer8_pkg::CS_STOP:     pre_tick = 1'b0;
		timer8_pkg::CS_DIV1:     pre_tick = 1'b1;
		timer8_pkg::CS_DIV8:     pre_tick =
			(presc_ff & pre_mask(timer8_pkg::PRE_DIV8))
			== pre_mask(timer8_pkg::PRE_DIV8);
		timer8_pkg::CS_DIV64:    pre_tick =
			(presc_ff & pre_mask(timer8_pkg::PRE_DIV64))
			== pre_mask(timer8_pkg::PRE_DIV64);
		timer8_pkg::CS_DIV256:   pre_tick =
			(presc_ff & pre_mask(timer8_pkg::PRE_DIV256))
			== pre_mask(timer8_pkg::PRE_DIV256);
		timer8_pkg::CS_DIV1024:  pre_tick =
			presc_ff == pre_mask(timer8_pkg::PRE_DIV1024);
		timer8_pkg::CS_EXT_FALL: pre_tick = ext_prev_ff & ~ext_count_pin;
		timer8_pkg::CS_EXT_RISE: pre_tick = ~ext_prev_ff & ext_count_pin;
		default:                 pre_tick = 1'b0;
		endcase
	end
	assign tmr_tick = pre_tick;

	// ==========================================================
	// counter unit
	assign phase_mode = (wmode == timer8_pkg::WM_PC_MAX)
		| (wmode == timer8_pkg::WM_PC_CMP);
	assign top_is_cmp = (wmode == timer8_pkg::WM_CTC)
		| (wmode == timer8_pkg::WM_PC_CMP)
		| (wmode == timer8_pkg::WM_FAST_CMP);
	assign top_val = top_is_cmp ? cmp_ff[0] : timer8_pkg::CNT_MAX; // see [R1]
	// a forced strobe is not part of the wrap test, see [R4]
	assign at_bottom_wrap = tmr_tick & ~phase_mode & (cnt_ff == top_val);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_ff      <= timer8_pkg::RST_CNT;
			dir_down_ff <= 1'b0;
		end else if (wr_cnt) begin
			cnt_ff <= pwdata[7:0]; // see [R11]
		end else if (tmr_tick) begin
			if (!phase_mode) begin
				dir_down_ff <= 1'b0;
				cnt_ff <= at_bottom_wrap ? timer8_pkg::CNT_BOTTOM
					: cnt_ff + 8'h01;
			end else if (!dir_down_ff) begin
				if (cnt_ff == top_val) begin
					dir_down_ff <= 1'b1;
					cnt_ff      <= cnt_ff - 8'h01;
				end else begin
					cnt_ff <= cnt_ff + 8'h01;
				end
			end else if (cnt_ff == timer8_pkg::CNT_BOTTOM) begin
				dir_down_ff <= 1'b0;
				cnt_ff      <= cnt_ff + 8'h01;
			end else begin
				cnt_ff <= cnt_ff - 8'h01;
			end
		end
	end

	// match suppression after a counter write
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			block_ff <= 1'b0;
		end else if (wr_cnt) begin
			block_ff <= 1'b1; // see [R12]
		end else if (tmr_tick) begin
			block_ff <= 1'b0;
		end
	end

	// overflow point depends on waveform mode, see [R15]
	always_comb begin
		case (wmode)
		timer8_pkg::WM_PC_MAX,
		timer8_pkg::WM_PC_CMP:   ovf_evt = tmr_tick & dir_down_ff
			& (cnt_ff == timer8_pkg::CNT_BOTTOM);
		timer8_pkg::WM_FAST_CMP: ovf_evt = tmr_tick & (cnt_ff == top_val);
		default:                 ovf_evt = tmr_tick
			& (cnt_ff == timer8_pkg::CNT_MAX);
		endcase
	end

	// ==========================================================
	// compare channels and waveform outputs
	generate
		for (genvar ch = 0; ch < 2; ch++) begin : g_chan
			// always compared, gated by tick and block, see [R13]
			assign hit[ch] = tmr_tick & ~block_ff & ~wr_cnt
				& (cnt_ff == cmp_ff[ch]);
			// strobe only, nothing stored, see [R2] see [R3]
			assign force_cmp[ch] = wr_ctrl_b & ~is_pwm(wmode)
				& pwdata[timer8_pkg::FORCE_A_BIT - ch];

			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					wave_ff[ch] <= 1'b0;
				end else if (!is_pwm(wmode)) begin
					if (hit[ch] || force_cmp[ch]) begin
						case (omode[ch]) // see [R20]
						timer8_pkg::OM_TOGGLE: wave_ff[ch] <= ~wave_ff[ch];
						timer8_pkg::OM_CLEAR:  wave_ff[ch] <= 1'b0;
						timer8_pkg::OM_SET:    wave_ff[ch] <= 1'b1;
						default:               wave_ff[ch] <= wave_ff[ch];
						endcase
					end
				end else if (hit[ch]) begin
					case (omode[ch])
					timer8_pkg::OM_TOGGLE: begin
						if (ch == 0 && wm_hi_ff) begin
							wave_ff[ch] <= ~wave_ff[ch];
						end
					end
					timer8_pkg::OM_CLEAR:
						wave_ff[ch] <= phase_mode & dir_down_ff;
					timer8_pkg::OM_SET:
						wave_ff[ch] <= ~(phase_mode & dir_down_ff);
					default: wave_ff[ch] <= wave_ff[ch];
					endcase
				end else if (at_bottom_wrap) begin
					case (omode[ch])
					timer8_pkg::OM_CLEAR: wave_ff[ch] <= 1'b1;
					timer8_pkg::OM_SET:   wave_ff[ch] <= 1'b0;
					default:              wave_ff[ch] <= wave_ff[ch];
					endcase
				end
			end
		end
	endgenerate

	assign wave_out_a      = wave_ff[0];
	assign wave_out_b      = wave_ff[1];
	assign wave_out_a_conn = (omode[0] != timer8_pkg::OM_OFF);
	assign wave_out_b_conn = (omode[1] != timer8_pkg::OM_OFF);

	// ==========================================================
	// flags and interrupt requests
	assign set_evt[timer8_pkg::BIT_CMP_A] = hit[0]; // see [R14]
	assign set_evt[timer8_pkg::BIT_CMP_B] = hit[1]; // see [R14]
	assign set_evt[timer8_pkg::BIT_OVF]   = ovf_evt;
	assign clr_evt[timer8_pkg::BIT_CMP_A] = vec_ack_cmp_a; // see [R17]
	assign clr_evt[timer8_pkg::BIT_OVF]   = vec_ack_ovf;
	assign clr_evt[timer8_pkg::BIT_CMP_B] = vec_ack_cmp_b;
	// set is applied last so a simultaneous event survives, see [R21]
	assign nxt_flags = (flags_ff & ~clr_evt
		& ~({3{wr_flags}} & pwdata[2:0])) | set_evt; // see [R18]

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			flags_ff <= timer8_pkg::RST_FLAGS;
		end else begin
			flags_ff <= nxt_flags;
		end
	end

	// see [R16]
	assign irq_cmp_a = global_irq_en & mask_ff[timer8_pkg::BIT_CMP_A]
		& flags_ff[timer8_pkg::BIT_CMP_A];
	assign irq_ovf   = global_irq_en & mask_ff[timer8_pkg::BIT_OVF]
		& flags_ff[timer8_pkg::BIT_OVF];
	assign irq_cmp_b = global_irq_en & mask_ff[timer8_pkg::BIT_CMP_B]
		& flags_ff[timer8_pkg::BIT_CMP_B];

	// ==========================================================
	// assertions
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	logic rd_ctrl_b;
	assign rd_ctrl_b = psel & penable & ~pwrite
		& reg_hit(paddr, timer8_pkg::IDX_CTRL_B);

	sequence s_cnt_write;
		wr_cnt;
	endsequence
	sequence s_next_tick;
		tmr_tick && !wr_cnt;
	endsequence

	property p_ctrl_b_zero_bits;
		rd_ctrl_b |-> (prdata[7:4] == 4'h0);
	endproperty
	a_ctrl_b_zero_bits: assert property (p_ctrl_b_zero_bits) // see [R5]
		else $error("control b force or reserved bits read nonzero");

	property p_force_pwm_ignored;
		(wr_ctrl_b && is_pwm(wmode)) |-> (force_cmp == 2'b00);
	endproperty
	a_force_pwm_ignored: assert property (p_force_pwm_ignored) // see [R2]
		else $error("force strobe acted in a pwm mode");

	property p_force_clear;
		(force_cmp[0] && !hit[0] && omode[0] == timer8_pkg::OM_CLEAR)
		|=> !wave_out_a;
	endproperty
	a_force_clear: assert property (p_force_clear) // see [R3]
		else $error("forced compare did not clear output a");

	property p_force_no_flag;
		(force_cmp[0] && !hit[0] && !flags_ff[timer8_pkg::BIT_CMP_A])
		|=> !flags_ff[timer8_pkg::BIT_CMP_A];
	endproperty
	a_force_no_flag: assert property (p_force_no_flag) // see [R4]
		else $error("forced compare set the compare flag");

	property p_write_blocks_match;
		s_cnt_write ##1 (block_ff and s_next_tick) |-> (hit == 2'b00);
	endproperty
	a_write_blocks_match: assert property (p_write_blocks_match) // see [R12]
		else $error("match not blocked after counter write");

	property p_match_sets_flag;
		hit[1] |=> flags_ff[timer8_pkg::BIT_CMP_B][*2] or
			(flags_ff[timer8_pkg::BIT_CMP_B] ##1 1'b1);
	endproperty
	a_match_sets_flag: assert property (p_match_sets_flag) // see [R14]
		else $error("compare b match did not set its flag");

	property p_set_beats_clear;
		(hit[0] && wr_flags && pwdata[timer8_pkg::BIT_CMP_A])
		|=> flags_ff[timer8_pkg::BIT_CMP_A];
	endproperty
	a_set_beats_clear: assert property (p_set_beats_clear) // see [R21]
		else $error("flag set lost to a same-cycle clear");

	property p_w1_clears;
		(wr_flags && pwdata[timer8_pkg::BIT_OVF] && !ovf_evt)
		|=> !flags_ff[timer8_pkg::BIT_OVF];
	endproperty
	a_w1_clears: assert property (p_w1_clears) // see [R18]
		else $error("write one did not clear overflow flag");

	property p_normal_wrap;
		(wmode == timer8_pkg::WM_NORMAL && tmr_tick && !wr_cnt
		&& cnt_ff == timer8_pkg::CNT_MAX)
		|=> (cnt_ff == timer8_pkg::CNT_BOTTOM)
		&& flags_ff[timer8_pkg::BIT_OVF];
	endproperty
	a_normal_wrap: assert property (p_normal_wrap) // see [R1] see [R15]
		else $error("normal mode wrap or overflow flag wrong");

	property p_clock_select;
		(cs_ff == timer8_pkg::CS_STOP |-> !tmr_tick) and
		(cs_ff == timer8_pkg::CS_DIV1 |-> tmr_tick);
	endproperty
	a_clock_select: assert property (p_clock_select) // see [R7]
		else $error("clock select decode wrong");

	property p_irq_gate;
		irq_ovf == (global_irq_en && mask_ff[timer8_pkg::BIT_OVF]
		&& flags_ff[timer8_pkg::BIT_OVF]);
	endproperty
	a_irq_gate: assert property (p_irq_gate) // see [R16]
		else $error("overflow interrupt gating wrong");

endmodule // timer8_ctrl_irq_regs

// [verilog/timer8_pkg.sv]
// constants for the 8-bit timer register block
package timer8_pkg;
	// ==========================================================
	// register indices (byte address is index times four)
	localparam logic [7:0] IDX_CMP_B  = 8'h17;
	localparam logic [7:0] IDX_CMP_A  = 8'h18;
	localparam logic [7:0] IDX_CNT    = 8'h19;
	localparam logic [7:0] IDX_CTRL_B = 8'h1a;
	localparam logic [7:0] IDX_CTRL_A = 8'h1b;
	localparam logic [7:0] IDX_FLAGS  = 8'h39;
	localparam logic [7:0] IDX_MASK   = 8'h3a;
	// ==========================================================
	// reset values
	localparam logic [7:0] RST_CMP    = 8'h00;
	localparam logic [7:0] RST_CNT    = 8'h00;
	localparam logic [7:0] RST_CTRL   = 8'h00;
	localparam logic [2:0] RST_FLAGS  = 3'h0;
	localparam logic [2:0] RST_MASK   = 3'h0;
	// ==========================================================
	// field positions
	localparam int FORCE_A_BIT = 7;
	localparam int FORCE_B_BIT = 6;
	localparam int WM_HI_BIT   = 3;
	localparam int CS_LSB      = 0;
	localparam int OM_A_LSB    = 6;
	localparam int OM_B_LSB    = 4;
	localparam int WM_LO_LSB   = 0;
	localparam int BIT_CMP_A   = 0;
	localparam int BIT_OVF     = 1;
	localparam int BIT_CMP_B   = 2;
	// ==========================================================
	// counter limits
	localparam logic [7:0] CNT_MAX    = 8'hff;
	localparam logic [7:0] CNT_BOTTOM = 8'h00;
	// ==========================================================
	// clock select codes and prescaler divisors
	localparam logic [2:0] CS_STOP     = 3'h0;
	localparam logic [2:0] CS_DIV1     = 3'h1;
	localparam logic [2:0] CS_DIV8     = 3'h2;
	localparam logic [2:0] CS_DIV64    = 3'h3;
	localparam logic [2:0] CS_DIV256   = 3'h4;
	localparam logic [2:0] CS_DIV1024  = 3'h5;
	localparam logic [2:0] CS_EXT_FALL = 3'h6;
	localparam logic [2:0] CS_EXT_RISE = 3'h7;
	localparam logic [10:0] PRE_DIV8    = 11'h008;
	localparam logic [10:0] PRE_DIV64   = 11'h040;
	localparam logic [10:0] PRE_DIV256  = 11'h100;
	localparam logic [10:0] PRE_DIV1024 = 11'h400;
	// ==========================================================
	// waveform modes and output modes
	localparam logic [2:0] WM_NORMAL   = 3'h0;
	localparam logic [2:0] WM_PC_MAX   = 3'h1;
	localparam logic [2:0] WM_CTC      = 3'h2;
	localparam logic [2:0] WM_FAST_MAX = 3'h3;
	localparam logic [2:0] WM_PC_CMP   = 3'h5;
	localparam logic [2:0] WM_FAST_CMP = 3'h7;
	localparam logic [1:0] OM_OFF      = 2'h0;
	localparam logic [1:0] OM_TOGGLE   = 2'h1;
	localparam logic [1:0] OM_CLEAR    = 2'h2;
	localparam logic [1:0] OM_SET      = 2'h3;
endpackage
